// ### core/vic_arb_if.sv
// Purpose: carries pending sources to the arbiter and the winner back
// Assumes: one requester, one arbiter
// Notes:   prio_flat holds 3 bits per request number
`timescale 1ns/100ps
interface vic_arb_if #(parameter int NUM_REQ = 151);
  import vic_pkg::*;
  logic [NUM_REQ-1:0] active;
  logic [NUM_REQ*3-1:0] prio_flat;
  vic_level_t cpu_level;
  logic win_valid;
  vic_vector_t win_irq;
  vic_prio_t win_prio;
  modport requester (output active, output prio_flat, output cpu_level,
    input win_valid, input win_irq, input win_prio);
  modport arbiter (input active, input prio_flat, input cpu_level,
    output win_valid, output win_irq, output win_prio);
endinterface

// ### core/vic_arbiter.sv
// Purpose: picks the highest ranked pending request above the cpu level
// Assumes: active already gated by enable, global gate and nesting
// Notes:   purely combinational
`timescale 1ns/100ps
module vic_arbiter #(parameter int NUM_REQ = 151)
(
  vic_arb_if.arbiter arb
);
  import vic_pkg::*;

  initial
  begin
    if (NUM_REQ < 1 || NUM_REQ > 256)
      $error("vic_arbiter: NUM_REQ out of range");
  end

  always_comb
  begin
    vic_prio_t p;
    p = '0;
    arb.win_valid = 1'b0;
    arb.win_irq = '0;
    arb.win_prio = '0;
    // downward scan with >= lets the lower request number win a tie
    for (int i = NUM_REQ - 1; i >= 0; i--)
    begin
      p = arb.prio_flat[i*3 +: 3];
      if (arb.active[i] && ({1'b0, p} > arb.cpu_level) &&
          (!arb.win_valid || p >= arb.win_prio))
      begin
        arb.win_valid = 1'b1;
        arb.win_irq = 8'(i);
        arb.win_prio = p;
      end
    end
  end
endmodule

// ### core/vic_edge_detect.sv
// Purpose: turns external request levels into one-cycle edge pulses
// Assumes: inputs synchronous to i_clock
// Notes:   polarity 1 detects falling edges, 0 rising
`timescale 1ns/100ps
module vic_edge_detect #(parameter int NUM = 3)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [NUM-1:0] i_level,
  input wire logic [NUM-1:0] i_falling,
  output logic [NUM-1:0] o_pulse
);
  logic [NUM-1:0] prev_reg;

  initial
  begin
    if (NUM < 1)
      $error("vic_edge_detect: NUM must be at least 1");
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      prev_reg <= '0;
    else
      prev_reg <= i_level;
  end

  // edge select per input
  assign o_pulse = (i_falling & prev_reg & ~i_level) | (~i_falling & ~prev_reg & i_level);
endmodule

// ### core/vic_pkg.sv
// Purpose: shared types of the interrupt controller
// Assumes: nothing
// Notes:   numbers live in vic_regs.svh
package vic_pkg;
  typedef logic [2:0] vic_prio_t;
  typedef logic [3:0] vic_level_t;
  typedef logic [7:0] vic_vector_t;
  typedef enum logic [1:0] {VIC_BUS_IDLE, VIC_BUS_WRITE, VIC_BUS_READ} vic_bus_state_t;
endpackage

// ### core/vic_regs.svh
// Purpose: register offsets, field positions, reset values of the interrupt controller
// Assumes: 32-bit AHB-Lite words, one register per aligned word
// Notes:   definitions only
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define VIC_OFS_TRAP_CTRL 12'h000
`define VIC_OFS_GLOBAL_CTRL 12'h004
`define VIC_OFS_SOFT_TRAP 12'h008
`define VIC_OFS_HARD_TRAP 12'h00c
`define VIC_OFS_TAKEN 12'h010
`define VIC_OFS_FLAG_BASE 12'h100
`define VIC_OFS_ENABLE_BASE 12'h180
`define VIC_OFS_PRIO_BASE 12'h200
`define VIC_OFS_WINDOW_MASK 12'h07f

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define VIC_NESTING_DISABLE_BIT 15
`define VIC_TRAP_RW_MASK 16'h8700
`define VIC_TRAP_FLAG_MASK 16'h78fe
`define VIC_GATE_BIT 15
`define VIC_DISI_BIT 14
`define VIC_SWTRAP_BIT 13
`define VIC_GLOBAL_RW_MASK 16'ha007
`define VIC_SOFT_TRAP_MASK 16'h0030
`define VIC_HARD_TRAP_BIT 0
`define VIC_WORD_RESET 16'h0000

// ----------------------------------------------------------------
// vectors and addresses
// ----------------------------------------------------------------
`define VIC_VECTOR_OFFSET 8
`define VIC_IVT_BASE 24'h000004
`define VIC_RESET_ADDR 24'h000000
`define VIC_EXT0_IRQ 0
`define VIC_EXT1_IRQ 20
`define VIC_EXT2_IRQ 29
`define VIC_NUM_EXT 3
`define VIC_MAX_REQ 246

`endif

// ### core/vic_top.sv
// Contract
// - reset forces execution address to zero
// - one flag per source, software clears
// - per-source enable gates each pending flag
// - writable 3-bit priority per source
// - accept captures vector number and level
// - captured level equals taken source priority
// - bits allocated in request-number order
// - external request zero is vector 8
// - trap word: nesting disable plus trap flags
// - global word: gate plus external edge controls
// - soft trap word: dma and loop overflow
// - hard trap word: software hard trap bit
// - polarity 1 falling, 0 rising edge
// - global gate 0 blocks all requests
// - cpu level 7 holds off user interrupts
//
// Purpose: vectored, prioritised interrupt controller with AHB-Lite registers
// Assumes: all inputs synchronous to i_clock; single word transfers only
// Notes:   reads take one wait state, writes none; response always OKAY
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`include "vic_regs.svh"
module vic_top #(parameter int NUM_REQ = 151)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic [NUM_REQ-1:0] i_src_request,
  input wire logic [2:0] i_external_request,
  input wire logic [15:0] i_trap_event,
  input wire logic [15:0] i_soft_trap_event,
  input wire logic i_hard_trap_event,
  input wire logic i_disi_active,
  input wire vic_pkg::vic_level_t i_cpu_priority_level,
  input wire logic i_isr_active,
  input wire logic i_irq_ack,
  output logic o_irq_request,
  output vic_pkg::vic_vector_t o_irq_vector,
  output vic_pkg::vic_level_t o_irq_level,
  output logic [23:0] o_vector_addr
);
  import vic_pkg::*;

  localparam int NUM_FW = (NUM_REQ + 15) / 16;
  localparam int NUM_PW = (NUM_REQ + 3) / 4;

  initial
  begin
    if (NUM_REQ <= `VIC_EXT2_IRQ || NUM_REQ > `VIC_MAX_REQ)
      $error("vic_top: NUM_REQ must cover the external requests and stay within range");
  end

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // reserved request numbers own no flag, enable or priority
  function automatic logic is_implemented(input int n);
    logic r;
    r = !((n == 15) || (n >= 21 && n <= 23) || (n == 34) || (n == 35) ||
          (n >= 39 && n <= 48) || (n >= 51 && n <= 56) || (n >= 59 && n <= 64) ||
          (n >= 68 && n <= 76) || (n >= 78 && n <= 93) || (n >= 97 && n <= 141) ||
          (n == 143) || (n == 144) ||
          (n >= 151));
    return r;
  endfunction

  function automatic int word_index(input logic [11:0] addr, input logic [11:0] base);
    logic [11:0] d;
    d = addr - base;
    return int'(d[11:2]);
  endfunction

  function automatic logic in_window(input logic [11:0] addr, input logic [11:0] base,
                                     input int words);
    return (addr >= base) && (word_index(addr, base) < words) && (addr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  vic_bus_state_t bus_state_reg;
  logic [11:0] bus_addr_reg;
  logic [NUM_REQ-1:0] flag_reg;
  logic [NUM_REQ-1:0] flag_next;
  logic [NUM_REQ-1:0] enable_reg;
  logic [NUM_REQ-1:0] enable_next;
  vic_prio_t prio_reg [NUM_REQ];
  vic_prio_t prio_next [NUM_REQ];
  logic [15:0] trap_control_word_reg;
  logic [15:0] global_control_word_reg;
  logic [15:0] soft_trap_status_word_reg;
  logic [15:0] hard_trap_status_word_reg;
  logic [15:0] taken_vector_status_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire accept = i_hsel && i_htrans[1] && i_hready;
  wire wr_now = (bus_state_reg == VIC_BUS_WRITE);
  wire [15:0] wdata = i_hwdata[15:0];
  wire sel_trap = wr_now && (bus_addr_reg == `VIC_OFS_TRAP_CTRL);
  wire sel_global = wr_now && (bus_addr_reg == `VIC_OFS_GLOBAL_CTRL);
  wire sel_soft = wr_now && (bus_addr_reg == `VIC_OFS_SOFT_TRAP);
  wire sel_hard = wr_now && (bus_addr_reg == `VIC_OFS_HARD_TRAP);
  wire sel_flag = wr_now && in_window(bus_addr_reg, `VIC_OFS_FLAG_BASE, NUM_FW);
  wire sel_enable = wr_now && in_window(bus_addr_reg, `VIC_OFS_ENABLE_BASE, NUM_FW);
  wire sel_prio = wr_now && in_window(bus_addr_reg, `VIC_OFS_PRIO_BASE, NUM_PW);
  wire [31:0] flag_word_idx = 32'(word_index(bus_addr_reg, `VIC_OFS_FLAG_BASE));
  wire [31:0] enable_word_idx = 32'(word_index(bus_addr_reg, `VIC_OFS_ENABLE_BASE));
  wire [31:0] prio_word_idx = 32'(word_index(bus_addr_reg, `VIC_OFS_PRIO_BASE));

  // ----------------------------------------------------------------
  // external edge detection
  // ----------------------------------------------------------------
  logic [2:0] ext_pulse;

  vic_edge_detect #(.NUM(`VIC_NUM_EXT)) u_edge (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_level(i_external_request),
    .i_falling(global_control_word_reg[2:0]),
    .o_pulse(ext_pulse)
  );

  logic [NUM_REQ-1:0] set_vec;
  always_comb
  begin
    set_vec = i_src_request;
    set_vec[`VIC_EXT0_IRQ] = i_src_request[`VIC_EXT0_IRQ] | ext_pulse[0];
    set_vec[`VIC_EXT1_IRQ] = i_src_request[`VIC_EXT1_IRQ] | ext_pulse[1];
    set_vec[`VIC_EXT2_IRQ] = i_src_request[`VIC_EXT2_IRQ] | ext_pulse[2];
  end

  // ----------------------------------------------------------------
  // per-source next values
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int n = 0; n < NUM_REQ; n++)
    begin
      flag_next[n] = flag_reg[n];
      enable_next[n] = enable_reg[n];
      prio_next[n] = prio_reg[n];
      if (sel_flag && flag_word_idx == 32'(n / 16))
        flag_next[n] = wdata[n % 16];
      if (sel_enable && enable_word_idx == 32'(n / 16))
        enable_next[n] = wdata[n % 16];
      if (sel_prio && prio_word_idx == 32'(n / 4))
        prio_next[n] = wdata[(n % 4) * 4 +: 3];
      // a set arriving with a clearing write still wins
      flag_next[n] = (flag_next[n] | set_vec[n]) & is_implemented(n);
      enable_next[n] = enable_next[n] & is_implemented(n);
      if (!is_implemented(n))
        prio_next[n] = '0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      flag_reg <= '0;
      enable_reg <= '0;
      for (int n = 0; n < NUM_REQ; n++)
        prio_reg[n] <= '0;
    end
    else
    begin
      flag_reg <= flag_next;
      enable_reg <= enable_next;
      prio_reg <= prio_next;
    end
  end

  // ----------------------------------------------------------------
  // control and trap words
  // ----------------------------------------------------------------
  wire [15:0] trap_next = ((sel_trap ? wdata : trap_control_word_reg) &
    (`VIC_TRAP_RW_MASK | `VIC_TRAP_FLAG_MASK)) | (i_trap_event & `VIC_TRAP_FLAG_MASK);
  wire [15:0] global_next = (sel_global ? wdata : global_control_word_reg) &
    `VIC_GLOBAL_RW_MASK;
  wire [15:0] soft_next = ((sel_soft ? wdata : soft_trap_status_word_reg) |
    i_soft_trap_event) & `VIC_SOFT_TRAP_MASK;
  wire hard_next = (sel_hard ? wdata[`VIC_HARD_TRAP_BIT] :
    hard_trap_status_word_reg[`VIC_HARD_TRAP_BIT]) | i_hard_trap_event;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      trap_control_word_reg <= `VIC_WORD_RESET;
      global_control_word_reg <= `VIC_WORD_RESET;
      soft_trap_status_word_reg <= `VIC_WORD_RESET;
      hard_trap_status_word_reg <= `VIC_WORD_RESET;
    end
    else
    begin
      trap_control_word_reg <= trap_next;
      global_control_word_reg <= global_next;
      soft_trap_status_word_reg <= soft_next;
      hard_trap_status_word_reg <= {15'h0000, hard_next};
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  vic_arb_if #(.NUM_REQ(NUM_REQ)) arb_bus ();

  wire global_irq_gate = global_control_word_reg[`VIC_GATE_BIT];
  wire nesting_disable = trap_control_word_reg[`VIC_NESTING_DISABLE_BIT];
  wire nest_block = nesting_disable && i_isr_active;

  assign arb_bus.active = (flag_reg & enable_reg) &
    {NUM_REQ{global_irq_gate && !nest_block}};
  assign arb_bus.cpu_level = i_cpu_priority_level;

  genvar g;
  generate
    for (g = 0; g < NUM_REQ; g++)
    begin : g_prio
      assign arb_bus.prio_flat[g*3 +: 3] = prio_reg[g];
    end
  endgenerate

  vic_arbiter #(.NUM_REQ(NUM_REQ)) u_arbiter (
    .arb(arb_bus.arbiter)
  );

  wire [7:0] win_vector = arb_bus.win_irq + 8'(`VIC_VECTOR_OFFSET);
  wire [23:0] win_addr = `VIC_IVT_BASE + {15'h0000, win_vector, 1'b0};

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_irq_request <= 1'b0;
      o_irq_vector <= '0;
      o_irq_level <= '0;
      o_vector_addr <= `VIC_RESET_ADDR;
      taken_vector_status_reg <= `VIC_WORD_RESET;
    end
    else
    begin
      o_irq_request <= arb_bus.win_valid;
      o_irq_vector <= win_vector;
      o_irq_level <= {1'b0, arb_bus.win_prio};
      o_vector_addr <= win_addr;
      if (i_irq_ack && o_irq_request)
        taken_vector_status_reg <= {4'h0, o_irq_level, o_irq_vector};
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [NUM_FW*16-1:0] flag_pad;
  logic [NUM_FW*16-1:0] enable_pad;
  logic [NUM_PW*16-1:0] prio_pad;

  always_comb
  begin
    flag_pad = '0;
    enable_pad = '0;
    prio_pad = '0;
    flag_pad[NUM_REQ-1:0] = flag_reg;
    enable_pad[NUM_REQ-1:0] = enable_reg;
    for (int n = 0; n < NUM_REQ; n++)
      prio_pad[(n / 4) * 16 + (n % 4) * 4 +: 3] = prio_reg[n];
  end

  logic [15:0] rd_word;
  always_comb
  begin
    rd_word = 16'h0000;
    if (bus_addr_reg == `VIC_OFS_TRAP_CTRL)
      rd_word = trap_control_word_reg;
    else if (bus_addr_reg == `VIC_OFS_GLOBAL_CTRL)
      rd_word = global_control_word_reg | (16'(i_disi_active) << `VIC_DISI_BIT);
    else if (bus_addr_reg == `VIC_OFS_SOFT_TRAP)
      rd_word = soft_trap_status_word_reg;
    else if (bus_addr_reg == `VIC_OFS_HARD_TRAP)
      rd_word = hard_trap_status_word_reg;
    else if (bus_addr_reg == `VIC_OFS_TAKEN)
      rd_word = taken_vector_status_reg;
    else if (in_window(bus_addr_reg, `VIC_OFS_FLAG_BASE, NUM_FW))
      rd_word = flag_pad[word_index(bus_addr_reg, `VIC_OFS_FLAG_BASE) * 16 +: 16];
    else if (in_window(bus_addr_reg, `VIC_OFS_ENABLE_BASE, NUM_FW))
      rd_word = enable_pad[word_index(bus_addr_reg, `VIC_OFS_ENABLE_BASE) * 16 +: 16];
    else if (in_window(bus_addr_reg, `VIC_OFS_PRIO_BASE, NUM_PW))
      rd_word = prio_pad[word_index(bus_addr_reg, `VIC_OFS_PRIO_BASE) * 16 +: 16];
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bus_state_reg <= VIC_BUS_IDLE;
      bus_addr_reg <= '0;
      o_hreadyout <= 1'b1;
      o_hrdata <= '0;
      o_hresp <= 1'b0;
    end
    else
    begin
      o_hresp <= 1'b0;
      // one wait state lets the read mux see the latched address
      if (bus_state_reg == VIC_BUS_READ)
      begin
        o_hrdata <= {16'h0000, rd_word};
        o_hreadyout <= 1'b1;
        bus_state_reg <= VIC_BUS_IDLE;
      end
      else if (accept)
      begin
        bus_addr_reg <= i_haddr[11:0];
        bus_state_reg <= i_hwrite ? VIC_BUS_WRITE : VIC_BUS_READ;
        o_hreadyout <= i_hwrite;
      end
      else
        bus_state_reg <= VIC_BUS_IDLE;
    end
  end
endmodule

// ### verif/vic_cpu_model.sv
// Purpose: behavioural cpu core facing the controller
// Assumes: level set by the bench, ack only when enabled
// Notes:   one ack pulse per service
`timescale 1ns/100ps
module vic_cpu_model
  import vic_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_irq_request,
  input wire logic i_ack_on,
  input wire logic i_isr_done,
  input wire vic_pkg::vic_level_t i_base_level,
  input wire logic [23:0] i_vector_addr,
  output vic_pkg::vic_level_t o_cpu_priority_level,
  output logic o_isr_active,
  output logic o_irq_ack,
  output logic [23:0] o_fetch_addr
);
  // unused slots hold the reset handler address
  localparam logic [23:0] DEFAULT_HANDLER = 24'h000000;
  assign o_cpu_priority_level = i_base_level;
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_isr_active <= 1'b0;
      o_irq_ack <= 1'b0;
      o_fetch_addr <= DEFAULT_HANDLER;
    end
    else
    begin
      o_irq_ack <= i_ack_on && i_irq_request && !o_irq_ack && !o_isr_active;
      if (o_irq_ack)
      begin
        o_isr_active <= 1'b1;
        o_fetch_addr <= i_vector_addr;
      end
      else if (i_isr_done)
        o_isr_active <= 1'b0;
    end
  end
endmodule

// ### verif/vic_top_properties.sv
// Purpose: port-level properties of the interrupt controller
// Assumes: sees only the top module ports
// Notes:   bound to vic_top after endmodule
`timescale 1ns/100ps
module vic_top_checker
  import vic_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hresp,
  input wire vic_pkg::vic_level_t i_cpu_priority_level,
  input wire logic o_irq_request,
  input wire vic_pkg::vic_vector_t o_irq_vector,
  input wire vic_pkg::vic_level_t o_irq_level,
  input wire logic [23:0] o_vector_addr
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------
  // bus and request sequences
  // ----------------------------------------------------------------
  sequence rd_take;
    i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  endsequence
  sequence wr_take;
    i_hsel && i_htrans[1] && i_hready && i_hwrite;
  endsequence
  sequence one_wait;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  chk_read_wait: assert property (rd_take |=> one_wait)
    else $error("read wait state wrong");
  chk_write_fast: assert property (wr_take |=> o_hreadyout)
    else $error("write stalled");
  chk_resp_okay: assert property (o_hresp == 1'b0)
    else $error("response not okay");
  chk_upper_zero: assert property (o_hreadyout |-> o_hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_vector_addr: assert property (
    o_irq_request |-> o_vector_addr == 24'h000004 + {15'h0000, o_irq_vector, 1'b0})
    else $error("vector address wrong");
  chk_vector_floor: assert property (
    o_irq_request |-> o_irq_vector >= 8'h08 && o_irq_vector != 8'h17)
    else $error("vector out of user range");
  chk_level_above: assert property (
    o_irq_request && $stable(i_cpu_priority_level)
      |-> o_irq_level > i_cpu_priority_level && !o_irq_level[3])
    else $error("request not above cpu level");
  chk_level7_hold: assert property (
    (i_cpu_priority_level >= 4'h7) [*2] |-> !o_irq_request)
    else $error("request at cpu level 7");
endmodule

bind vic_top vic_top_checker vic_top_checker_i (.i_clock(i_clock), .i_nrst(i_nrst),
  .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
  .i_cpu_priority_level(i_cpu_priority_level), .o_irq_request(o_irq_request),
  .o_irq_vector(o_irq_vector), .o_irq_level(o_irq_level), .o_vector_addr(o_vector_addr));

// ### verif/vic_top_test.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: one AHB-Lite master, cpu model on the far side
// Notes:   register offsets as chosen in vic_regs.svh
`timescale 1ns/100ps
module vic_top_test;
  import vic_pkg::*;
  logic i_clock, i_nrst, i_hsel, i_hwrite, ack_on, isr_done, o_hreadyout, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rdata;
  logic [1:0] i_htrans;
  logic [150:0] i_src_request;
  logic [2:0] i_external_request;
  logic [15:0] i_trap_event, i_soft_trap_event;
  logic i_hard_trap_event, i_disi_active, isr_active, irq_ack, o_irq_request;
  vic_level_t base_level, cpu_level, o_irq_level;
  vic_vector_t o_irq_vector;
  logic [23:0] o_vector_addr, fetch_addr;
  int num_errors, comparisons;
  vic_top vic_top_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'b010),
    .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hresp(o_hresp), .i_src_request(i_src_request),
    .i_external_request(i_external_request), .i_trap_event(i_trap_event),
    .i_soft_trap_event(i_soft_trap_event), .i_hard_trap_event(i_hard_trap_event),
    .i_disi_active(i_disi_active), .i_cpu_priority_level(cpu_level),
    .i_isr_active(isr_active), .i_irq_ack(irq_ack), .o_irq_request(o_irq_request),
    .o_irq_vector(o_irq_vector), .o_irq_level(o_irq_level), .o_vector_addr(o_vector_addr));
  vic_cpu_model vic_cpu_model_i (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_irq_request(o_irq_request), .i_ack_on(ack_on), .i_isr_done(isr_done),
    .i_base_level(base_level), .i_vector_addr(o_vector_addr),
    .o_cpu_priority_level(cpu_level), .o_isr_active(isr_active), .o_irq_ack(irq_ack),
    .o_fetch_addr(fetch_addr));
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [15:0] d);
    i_haddr <= {20'h00000, a};
    i_hwrite <= w;
    i_htrans <= 2'b10;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'b00;
    i_hwdata <= {16'h0000, d};
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    rdata = o_hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 16'h0000);
    check(rdata, exp, what);
    check({31'h0, o_hresp}, 32'h0, "response okay");
  endtask
  task automatic settle;
    repeat (4) @(posedge i_clock);
  endtask
  task automatic pulse_src(input int n);
    i_src_request[n] <= 1'b1;
    @(posedge i_clock);
    i_src_request[n] <= 1'b0;
    settle;
  endtask
  task automatic irq(input logic r, input logic [7:0] v, input logic [3:0] l, input string w);
    if (r)
      check({19'h0, o_irq_request, o_irq_vector, o_irq_level}, {19'h0, r, v, l}, w);
    else
      check({31'h0, o_irq_request}, 32'h0, w);
  endtask
  initial
  begin
    #200000;
    num_errors++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_nrst = 1'b0;
    i_hsel = 1'b1;
    i_haddr = '0;
    i_hwrite = 1'b0;
    i_htrans = 2'b00;
    i_hwdata = '0;
    i_src_request = '0;
    i_external_request = 3'h0;
    i_trap_event = 16'h0000;
    i_soft_trap_event = 16'h0000;
    i_hard_trap_event = 1'b0;
    i_disi_active = 1'b0;
    base_level = 4'h0;
    ack_on = 1'b0;
    isr_done = 1'b0;
    num_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge i_clock);
    check({8'h00, o_vector_addr}, 32'h0, "reset address");
    i_nrst <= 1'b1;
    @(posedge i_clock);
    for (int k = 0; k < 5; k++) rd(12'(4 * k), 32'h0, "reset word");
    wr(12'h004, 16'h8000);
    wr(12'h200, 16'hffff);
    rd(12'h200, 32'h7777, "priority slots");
    rd(12'h800, 32'h0, "unmapped read");
    wr(12'h200, 16'h0243);
    pulse_src(0);
    irq(1'b0, 8'h00, 4'h0, "disabled source");
    rd(12'h100, 32'h1, "flag of request zero");
    wr(12'h180, 16'h0007);
    settle;
    irq(1'b1, 8'h08, 4'h3, "external zero");
    check({8'h00, o_vector_addr}, 32'h14, "vector address");
    pulse_src(1);
    irq(1'b1, 8'h09, 4'h4, "higher priority");
    wr(12'h200, 16'h0233);
    settle;
    irq(1'b1, 8'h08, 4'h3, "tie order");
    wr(12'h004, 16'h0000);
    settle;
    irq(1'b0, 8'h00, 4'h0, "gate closed");
    wr(12'h004, 16'h8000);
    base_level <= 4'h3;
    settle;
    irq(1'b0, 8'h00, 4'h0, "not above level");
    wr(12'h200, 16'h0237);
    base_level <= 4'h7;
    settle;
    irq(1'b0, 8'h00, 4'h0, "cpu level seven");
    base_level <= 4'h6;
    settle;
    irq(1'b1, 8'h08, 4'h7, "above level six");
    base_level <= 4'h0;
    ack_on <= 1'b1;
    settle;
    ack_on <= 1'b0;
    rd(12'h010, 32'h0708, "taken status");
    check({8'h00, fetch_addr}, 32'h14, "fetch address");
    wr(12'h000, 16'h8000);
    settle;
    irq(1'b0, 8'h00, 4'h0, "nesting held");
    isr_done <= 1'b1;
    @(posedge i_clock);
    isr_done <= 1'b0;
    settle;
    irq(1'b1, 8'h08, 4'h7, "service ended");
    wr(12'h000, 16'h0000);
    wr(12'h100, 16'hffff);
    rd(12'h100, 32'h7fff, "reserved flag");
    wr(12'h100, 16'h0000);
    settle;
    irq(1'b0, 8'h00, 4'h0, "flags cleared");
    pulse_src(17);
    rd(12'h104, 32'h2, "second flag word");
    i_external_request[0] <= 1'b1;
    settle;
    rd(12'h100, 32'h1, "rising edge");
    wr(12'h100, 16'h0000);
    wr(12'h004, 16'h8001);
    i_external_request[0] <= 1'b0;
    settle;
    rd(12'h100, 32'h1, "falling edge");
    wr(12'h100, 16'h0000);
    i_external_request[0] <= 1'b1;
    settle;
    rd(12'h100, 32'h0, "rising ignored");
    i_external_request[2:1] <= 2'b11;
    settle;
    rd(12'h104, 32'h2012, "external one and two");
    i_trap_event <= 16'h0002;
    i_soft_trap_event <= 16'h0030;
    i_hard_trap_event <= 1'b1;
    @(posedge i_clock);
    i_trap_event <= 16'h0000;
    i_soft_trap_event <= 16'h0000;
    i_hard_trap_event <= 1'b0;
    i_disi_active <= 1'b1;
    settle;
    rd(12'h000, 32'h2, "trap flag");
    rd(12'h008, 32'h30, "soft trap flags");
    rd(12'h00c, 32'h1, "hard trap flag");
    wr(12'h004, 16'ha001);
    rd(12'h004, 32'he001, "global word");
    print_verdict;
  end
endmodule
